// File: rtl/dmx_uart.sv
// dmx512 controller and receiver mode of an asynchronous serial port
// assumes: plain register port, read data one cycle after the read strobe
// What this block does
// - dmx only on port zero, mode 1010
// - controller break lasts 25 bit times
// - mab, start code, then n+1 bytes, n from txcnt
// - transmit ready flag when buffer free
// - after n+1 data bytes insert break, reset count
// - break accepted only after 23 bits
// - valid break resets receive counters
// - mark after break is not data
// - start code always stored
// - store only channels first through last
// - channel counter starts at zero
// - two byte fifo, overrun flagged
// - low stop bit sets framing error
// - break received flag on every break
// - eight enable bits gate error sources
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "dmx_uart_regs.svh"
module dmx_uart #(
   parameter bit PORT_ZERO = 1'b1
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register port
   input dmx_uart_pkg::reg_req_type reg_req,
   output logic [15:0] reg_rdata,
   // serial line
   input wire logic rx_pin,
   output logic tx_pin,
   // interrupt line gated by the error enables
   output logic err_irq
);
   import dmx_uart_pkg::*;

   logic [9:0] ctrl_reg;
   logic [15:0] txcnt_reg;
   logic [15:0] rxfirst_reg;
   logic [15:0] rxlast_reg;
   logic [15:0] baud_reg;
   logic [7:0] errie_reg;
   logic brk_flag_reg;
   logic ferr_flag_reg;
   logic ovf_flag_reg;
   logic rx_meta_reg;
   logic rx_sync_reg;

   // transmit side
   tx_state_type tx_state_reg;
   logic [7:0] txbuf_reg;
   logic txbuf_full_reg;
   logic [10:0] tx_shift_reg;
   logic [15:0] tx_tick_reg;
   logic [5:0] tx_bits_reg;
   logic [15:0] tx_count_reg;
   logic tx_line_reg;

   // receive side
   dmx_rx_state_type rx_state_reg;
   logic [15:0] chan_reg;
   rx_byte_type fifo_reg [2];
   logic fifo_wp_reg;
   logic fifo_rp_reg;
   logic [1:0] fifo_cnt_reg;

   rx_byte_type rx_byte;
   logic rx_valid;
   logic rx_break;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction : hit

   wire dmx_on = PORT_ZERO &&
      ctrl_reg[`CTRL_MODE_LSB +: 4] == `MODE_DMX;
   wire tx_on = dmx_on && ctrl_reg[`CTRL_TXON];
   wire rx_on = dmx_on && ctrl_reg[`CTRL_RXON];
   wire wr_txbuf = reg_req.wr && hit(reg_req.addr, `OFF_TXBUF);
   wire rd_rxbuf = reg_req.rd && hit(reg_req.addr, `OFF_RXBUF);
   wire tx_ready = !txbuf_full_reg;
   wire tx_tick = (tx_tick_reg == baud_reg - 16'h0001);
   wire shifter_empty = (tx_state_reg == TX_IDLE) ||
      (tx_state_reg == TX_WAIT);
   wire fifo_empty = (fifo_cnt_reg == 2'h0);
   wire rx_line = rx_sync_reg ^ ctrl_reg[`CTRL_RECEIVE_POLARITY];
   wire [15:0] last_eff = (rxlast_reg > `CHAN_MAX) ? `CHAN_MAX : rxlast_reg;
   wire in_window = (chan_reg >= rxfirst_reg) && (chan_reg <= last_eff);
   wire store_start = rx_valid && rx_state_reg == RX_START;
   wire store_chan = rx_valid && rx_state_reg == RX_DATA &&
      in_window;
   wire store = store_start || store_chan;
   wire fifo_push = store && fifo_cnt_reg != 2'h2;
   wire fifo_pop = rd_rxbuf && !fifo_empty;
   wire overrun = store && fifo_cnt_reg == 2'h2;
   wire [7:0] err_src = {shifter_empty, 1'b0, 1'b0, 1'b0,
      ferr_flag_reg, brk_flag_reg, ovf_flag_reg, 1'b0};
   wire irq_any = |(err_src & errie_reg);
   wire [15:0] status_word = {8'h00, irq_any,
      fifo_reg[fifo_rp_reg].ferr & !fifo_empty, !fifo_empty, ovf_flag_reg,
      ferr_flag_reg, brk_flag_reg, shifter_empty, tx_ready};

   dmx_rx_bytes u_rx (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .enable(rx_on),
      .baud_div(baud_reg),
      .rx_in(rx_line),
      .byte_out(rx_byte),
      .byte_valid(rx_valid),
      .break_seen(rx_break)
   );

   // two flops before the pin is looked at
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rx_meta_reg <= 1'b1;
         rx_sync_reg <= 1'b1;
      end else begin
         rx_meta_reg <= rx_pin;
         rx_sync_reg <= rx_meta_reg;
      end
   end

   // register writes and sticky flags; a set beats a same-cycle clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl_reg <= 10'h000;
         txcnt_reg <= 16'h0000;
         rxfirst_reg <= 16'h0000;
         rxlast_reg <= `CHAN_MAX;
         baud_reg <= 16'(`DEF_BAUD_DIV);
         errie_reg <= `ERRIE_RESET;
         brk_flag_reg <= 1'b0;
         ferr_flag_reg <= 1'b0;
         ovf_flag_reg <= 1'b0;
      end else begin
         if (reg_req.wr) begin
            if (hit(reg_req.addr, `OFF_CTRL))
               ctrl_reg <= reg_req.wdata[9:0];
            else if (hit(reg_req.addr, `OFF_TXCNT))
               txcnt_reg <= reg_req.wdata;
            else if (hit(reg_req.addr, `OFF_RXFIRST))
               rxfirst_reg <= reg_req.wdata;
            else if (hit(reg_req.addr, `OFF_RXLAST))
               rxlast_reg <= reg_req.wdata;
            else if (hit(reg_req.addr, `OFF_BAUD))
               baud_reg <= (reg_req.wdata == 16'h0000) ? 16'h0001 :
                  reg_req.wdata;
            else if (hit(reg_req.addr, `OFF_ERRIE))
               errie_reg <= reg_req.wdata[7:0];
            else if (hit(reg_req.addr, `OFF_STATUS)) begin
               // write one to clear
               if (reg_req.wdata[`ST_BREAK])
                  brk_flag_reg <= 1'b0;
               if (reg_req.wdata[`ST_FERR])
                  ferr_flag_reg <= 1'b0;
               if (reg_req.wdata[`ST_OVF])
                  ovf_flag_reg <= 1'b0;
            end
         end
         if (rx_break)
            brk_flag_reg <= 1'b1;
         if (fifo_push && rx_byte.ferr)
            ferr_flag_reg <= 1'b1;
         if (overrun)
            ovf_flag_reg <= 1'b1;
      end
   end

   // read data one cycle after the strobe, unmapped reads return zero
   wire [15:0] rd_mux =
      hit(reg_req.addr, `OFF_CTRL) ? {6'h00, ctrl_reg} :
      hit(reg_req.addr, `OFF_TXCNT) ? txcnt_reg :
      hit(reg_req.addr, `OFF_RXFIRST) ? rxfirst_reg :
      hit(reg_req.addr, `OFF_RXLAST) ? rxlast_reg :
      hit(reg_req.addr, `OFF_BAUD) ? baud_reg :
      hit(reg_req.addr, `OFF_RXBUF) ?
         {8'h00, fifo_empty ? 8'h00 : fifo_reg[fifo_rp_reg].data} :
      hit(reg_req.addr, `OFF_STATUS) ? status_word :
      hit(reg_req.addr, `OFF_ERRIE) ? {8'h00, errie_reg} : 16'h0000;

   always_ff @(posedge core_clk) begin
      if (!rst_n)
         reg_rdata <= 16'h0000;
      else
         reg_rdata <= reg_req.rd ? rd_mux : 16'h0000;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n)
         err_irq <= 1'b0;
      else
         err_irq <= irq_any;
   end

   // receive fifo, two entries
   always_ff @(posedge core_clk) begin
      if (!rst_n || !rx_on) begin
         fifo_wp_reg <= 1'b0;
         fifo_rp_reg <= 1'b0;
         fifo_cnt_reg <= 2'h0;
         fifo_reg[0] <= '0;
         fifo_reg[1] <= '0;
      end else begin
         if (fifo_push) begin
            fifo_reg[fifo_wp_reg] <= rx_byte;
            fifo_wp_reg <= !fifo_wp_reg;
         end
         if (fifo_pop)
            fifo_rp_reg <= !fifo_rp_reg;
         fifo_cnt_reg <= fifo_cnt_reg + {1'b0, fifo_push} -
            {1'b0, fifo_pop};
      end
   end

   // receive frame tracking; bytes before a break are ignored
   always_ff @(posedge core_clk) begin
      if (!rst_n || !rx_on) begin
         rx_state_reg <= RX_IDLE;
         chan_reg <= 16'h0000;
      end else if (rx_break) begin
         // mab is simply idle line, no byte appears until start code
         rx_state_reg <= RX_START;
         chan_reg <= 16'h0000;
      end else if (rx_valid) begin
         case (rx_state_reg)
            RX_START: begin
               rx_state_reg <= RX_DATA;
               chan_reg <= 16'h0000;
            end
            RX_DATA: begin
               if (chan_reg >= last_eff)
                  rx_state_reg <= RX_DONE;
               chan_reg <= chan_reg + 16'h0001;
            end
            default: rx_state_reg <= rx_state_reg;
         endcase
      end
   end

   // transmit buffer: one byte held until the frame engine takes it
   wire tx_take = (tx_state_reg == TX_WAIT) && txbuf_full_reg;

   always_ff @(posedge core_clk) begin
      if (!rst_n || !tx_on)
         txbuf_full_reg <= 1'b0;
      else if (wr_txbuf && tx_ready)
         txbuf_full_reg <= 1'b1;
      else if (tx_take)
         txbuf_full_reg <= 1'b0;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n)
         txbuf_reg <= 8'h00;
      else if (wr_txbuf && tx_ready)
         txbuf_reg <= reg_req.wdata[7:0];
   end

   // frame engine: break, mab, then start code plus txcnt_reg + 1 data bytes
   always_ff @(posedge core_clk) begin
      if (!rst_n || !tx_on) begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= 11'h7FF;
         tx_tick_reg <= 16'h0000;
         tx_bits_reg <= 6'h00;
         tx_count_reg <= 16'h0000;
         tx_line_reg <= 1'b1;
      end else begin
         tx_tick_reg <= (tx_tick || tx_state_reg == TX_IDLE ||
            tx_state_reg == TX_WAIT) ? 16'h0000 : tx_tick_reg + 16'h0001;
         case (tx_state_reg)
            TX_IDLE: begin
               tx_line_reg <= 1'b1;
               if (txbuf_full_reg) begin
                  tx_state_reg <= TX_BREAK;
                  tx_bits_reg <= 6'h00;
                  tx_line_reg <= 1'b0;
               end
            end
            TX_BREAK: begin
               tx_line_reg <= 1'b0;
               if (tx_tick) begin
                  tx_bits_reg <= tx_bits_reg + 6'h01;
                  if (tx_bits_reg == 6'(`TX_BREAK_BITS - 1)) begin
                     tx_state_reg <= TX_MAB;
                     tx_bits_reg <= 6'h00;
                     tx_line_reg <= 1'b1;
                  end
               end
            end
            TX_MAB: begin
               tx_line_reg <= 1'b1;
               if (tx_tick) begin
                  tx_bits_reg <= tx_bits_reg + 6'h01;
                  if (tx_bits_reg == 6'(`TX_MAB_BITS - 1)) begin
                     tx_state_reg <= TX_WAIT;
                     tx_count_reg <= 16'h0000;
                  end
               end
            end
            TX_WAIT: begin
               tx_line_reg <= 1'b1;
               if (tx_take) begin
                  // start, 8 data lsb first, two stop bits
                  tx_shift_reg <= {2'b11, txbuf_reg, 1'b0};
                  tx_line_reg <= 1'b0;
                  tx_bits_reg <= 6'h00;
                  tx_state_reg <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               tx_line_reg <= tx_shift_reg[0];
               if (tx_tick) begin
                  tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                  tx_line_reg <= tx_shift_reg[1];
                  tx_bits_reg <= tx_bits_reg + 6'h01;
                  if (tx_bits_reg == 6'h0A) begin
                     tx_line_reg <= 1'b1;
                     tx_count_reg <= tx_count_reg + 16'h0001;
                     // start code is item 0, so the frame ends at count n+1, after n+1 data bytes
                     if (tx_count_reg == txcnt_reg + 16'h0001)
                        tx_state_reg <= TX_IDLE;
                     else
                        tx_state_reg <= TX_WAIT;
                  end
               end
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   // polarity applied at the pin; line idles high when disabled
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         tx_pin <= 1'b1;
      else
         tx_pin <= tx_on ? (tx_line_reg ^ ctrl_reg[`CTRL_TRANSMIT_POLARITY]) : 1'b1;
   end

endmodule : dmx_uart

// File: rtl/dmx_uart_regs.svh
// offsets, field positions, reset values and timing counts of the dmx port
// assumes: included by its bare name from package-aware design files
`ifndef DMX_UART_REGS_SVH
`define DMX_UART_REGS_SVH

`define CLK_HZ 40000000
`define BAUD_HZ 250000
`define DEF_BAUD_DIV (`CLK_HZ / `BAUD_HZ)
`define TX_BREAK_BITS 25
`define RX_BREAK_MIN_BITS 23
`define TX_MAB_BITS 2
`define CHAN_MAX 16'h01FF
`define MODE_DMX 4'hA
`define STOP_TWO 2'h2

`define OFF_CTRL 4'h0
`define OFF_TXCNT 4'h1
`define OFF_RXFIRST 4'h2
`define OFF_RXLAST 4'h3
`define OFF_BAUD 4'h4
`define OFF_TXBUF 4'h5
`define OFF_RXBUF 4'h6
`define OFF_STATUS 4'h7
`define OFF_ERRIE 4'h8

// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_TXON 4
`define CTRL_RXON 5
`define CTRL_STOP_LSB 6
`define CTRL_TRANSMIT_POLARITY 8
`define CTRL_RECEIVE_POLARITY 9

// status register fields
`define ST_TXRDY 0
`define ST_SHEMPTY 1
`define ST_BREAK 2
`define ST_FERR 3
`define ST_OVF 4
`define ST_RXAVAIL 5
`define ST_RXFERR 6
`define ST_IRQ 7

`define ERRIE_RESET 8'h00
`define ERRIE_SHEMPTY 7
`define ERRIE_FERR 3
`define ERRIE_BREAK 2
`define ERRIE_OVF 1

`endif

// File: rtl/dmx_uart_pkg.sv
// types shared by the dmx serial port
// assumes: compiled before every design file
package dmx_uart_pkg;

   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;

   typedef struct packed {
      logic [7:0] data;
      logic ferr;
   } rx_byte_type;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_BREAK = 3'b001,
      TX_MAB = 3'b010,
      TX_WAIT = 3'b011,
      TX_SHIFT = 3'b100
   } tx_state_type;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_DONE = 2'b11
   } dmx_rx_state_type;

endpackage : dmx_uart_pkg

// File: rtl/dmx_rx_bytes.sv
// serial byte receiver with break detection, oversampled by the baud divisor
// assumes: rx_in already synchronised and polarity corrected
`timescale 1ns/1ps
`include "dmx_uart_regs.svh"
module dmx_rx_bytes (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // setup
   input wire logic enable,
   input wire logic [15:0] baud_div,
   // line
   input wire logic rx_in,
   // results
   output dmx_uart_pkg::rx_byte_type byte_out,
   output logic byte_valid,
   output logic break_seen
);
   import dmx_uart_pkg::*;

   logic [15:0] tick_reg;
   logic [3:0] bit_reg;
   logic [7:0] shift_reg;
   logic busy_reg;
   logic [5:0] low_bits_reg;
   logic brk_done_reg;
   logic stop_bad_reg;
   wire [15:0] half = {1'b0, baud_div[15:1]};
   wire tick_end = (tick_reg == baud_div - 16'h0001);

   always_ff @(posedge core_clk) begin
      byte_valid <= 1'b0;
      break_seen <= 1'b0;
      if (!rst_n || !enable) begin
         tick_reg <= 16'h0000;
         bit_reg <= 4'h0;
         shift_reg <= 8'h00;
         busy_reg <= 1'b0;
         low_bits_reg <= 6'h00;
         brk_done_reg <= 1'b0;
         stop_bad_reg <= 1'b0;
         byte_out <= '0;
      end else begin
         // break length measured in whole bit times of continuous low
         if (rx_in) begin
            low_bits_reg <= 6'h00;
            brk_done_reg <= 1'b0;
         end else if (tick_end && low_bits_reg != 6'h3F) begin
            low_bits_reg <= low_bits_reg + 6'h01;
         end
         if (!rx_in && !brk_done_reg &&
             low_bits_reg == 6'(`RX_BREAK_MIN_BITS)) begin
            break_seen <= 1'b1;
            brk_done_reg <= 1'b1;
            busy_reg <= 1'b0;
         end
         tick_reg <= tick_end ? 16'h0000 : tick_reg + 16'h0001;
         if (!busy_reg) begin
            if (!rx_in && !brk_done_reg && low_bits_reg == 6'h00) begin
               busy_reg <= 1'b1;
               tick_reg <= baud_div - half;
               bit_reg <= 4'h0;
               stop_bad_reg <= 1'b0;
            end
         end else if (tick_end && !brk_done_reg) begin
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg >= 4'h1 && bit_reg <= 4'h8)
               shift_reg <= {rx_in, shift_reg[7:1]};
            if (bit_reg == 4'h9 && !rx_in)
               stop_bad_reg <= 1'b1;
            if (bit_reg == 4'hA) begin
               busy_reg <= 1'b0;
               byte_out.data <= shift_reg;
               byte_out.ferr <= stop_bad_reg | !rx_in;
               // both stops low is the front of a break, never data
               byte_valid <= rx_in | !stop_bad_reg;
            end
         end
      end
   end
endmodule : dmx_rx_bytes

// File: verif/dmx_uart_assertions.sv
// port-level checker for the dmx serial port
// assumes: bound to dmx_uart; register shadows follow the plain port
`timescale 1ns/1ps
`include "dmx_uart_regs.svh"
module dmx_uart_assertions
   import dmx_uart_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register port
   input dmx_uart_pkg::reg_req_type reg_req,
   input wire logic [15:0] reg_rdata,
   // serial line and interrupt
   input wire logic rx_pin,
   input wire logic tx_pin,
   input wire logic err_irq
);
   logic [15:0] baud_q;
   logic [4:0] ctrl_q;
   logic [7:0] ie_q;
   logic [19:0] run;
   logic tx_q;
   logic brk_q;
   logic ie_off_d;
   logic [1:0] quiet_d;
   wire [19:0] bit_len = (baud_q == 16'h0000) ? 20'h00001 : {4'h0, baud_q};
   wire [19:0] brk_len = bit_len * 20'h00019;
   wire [19:0] char_len = bit_len * 20'h00009;
   wire [19:0] mab_len = bit_len * 20'h00002;
   wire quiet = (ctrl_q[3:0] != `MODE_DMX) || !ctrl_q[4];
   wire tx_rise = tx_pin && !tx_q;
   wire tx_fall = !tx_pin && tx_q;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         baud_q <= 16'h00A0;
         ctrl_q <= 5'h00;
         ie_q <= 8'h00;
      end else if (reg_req.wr) begin
         if (reg_req.addr == `OFF_BAUD) baud_q <= reg_req.wdata;
         if (reg_req.addr == `OFF_CTRL) ctrl_q <= reg_req.wdata[4:0];
         if (reg_req.addr == `OFF_ERRIE) ie_q <= reg_req.wdata[7:0];
      end
   end

   // run length of the current tx level; a long low run can only be a break
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         run <= 20'h00000;
         tx_q <= 1'b1;
         brk_q <= 1'b0;
         quiet_d <= 2'h3;
         ie_off_d <= 1'b1;
      end else begin
         run <= (tx_pin != tx_q) ? 20'h00001 : run + 20'h00001;
         tx_q <= tx_pin;
         brk_q <= (tx_rise && run == brk_len) || (brk_q && !tx_fall);
         quiet_d <= {quiet_d[0], quiet};
         ie_off_d <= (ie_q == 8'h00);
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   AST_RDATA_IDLE: assert property (!reg_req.rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside read slot");
   AST_UNMAPPED_ZERO: assert property (
      reg_req.rd && reg_req.addr > `OFF_ERRIE |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   AST_ERRIE_READBACK: assert property (
      reg_req.rd && reg_req.addr == `OFF_ERRIE |=> reg_rdata == {8'h00, ie_q})
      else $error("error enable read back wrong");
   AST_TX_BREAK: assert property (
      tx_rise && run > char_len |-> run == brk_len)
      else $error("tx break width wrong");
   AST_TX_MAB: assert property (tx_fall && brk_q |-> run >= mab_len)
      else $error("mark after break too short");
   AST_TX_QUIET: assert property (quiet && (&quiet_d) |-> tx_pin)
      else $error("tx line active outside dmx controller mode");
   AST_IRQ_GATED: assert property (
      ie_off_d && ie_q == 8'h00 |-> !err_irq)
      else $error("interrupt with all enables clear");
   AST_RESET_IDLE: assert property (
      $rose(rst_n) |-> tx_pin && !err_irq && reg_rdata == 16'h0000)
      else $error("outputs not idle after reset");

   COV_BREAK: cover property (tx_rise && run == brk_len);
   COV_IRQ: cover property (err_irq);
   COV_RXBUF: cover property (
      reg_req.rd && reg_req.addr == `OFF_RXBUF ##1 reg_rdata != 16'h0000);
endmodule : dmx_uart_assertions

bind dmx_uart dmx_uart_assertions u_check (
   .core_clk(core_clk),
   .rst_n(rst_n),
   .reg_req(reg_req),
   .reg_rdata(reg_rdata),
   .rx_pin(rx_pin),
   .tx_pin(tx_pin),
   .err_irq(err_irq)
);

// File: verif/dmx_line_model.sv
// far end of the dmx line: decodes what the port sends, drives what it hears
// assumes: BIT core clocks per bit on both directions, line rests at mark
`timescale 1ns/1ps
`include "dmx_uart_regs.svh"
module dmx_line_model #(
   parameter int BIT = 16
) (
   // clock
   input wire logic core_clk,
   // line
   input wire logic tx_line,
   output logic rx_line
);
   logic [7:0] seen_q [$];
   int breaks = 0;

   initial rx_line = 1'b1;

   // mid-bit sampling; any low first stop counts as a break, whatever the data bits
   initial begin : decode
      logic [7:0] b;
      int n;
      forever begin
         @(posedge core_clk);
         if (tx_line === 1'b0) begin
            repeat (BIT / 2 + BIT) @(posedge core_clk);
            for (int i = 0; i < 8; i++) begin
               b[i] = tx_line;
               repeat (BIT) @(posedge core_clk);
            end
            if (tx_line === 1'b1) begin
               seen_q.push_back(b);
               repeat (BIT) @(posedge core_clk);
            end else begin
               breaks++;
               n = 0;
               while (tx_line !== 1'b1 && n < 100000) begin
                  @(posedge core_clk);
                  n++;
               end
            end
         end
      end
   end

   task automatic send_break(input int bits);
      @(posedge core_clk);
      rx_line <= 1'b0;
      repeat (bits * BIT) @(posedge core_clk);
      rx_line <= 1'b1;
      repeat (`TX_MAB_BITS * BIT) @(posedge core_clk);
   endtask : send_break

   // start, eight data lsb first, two stops; stop1 low forces a framing fault
   task automatic send_byte(input logic [7:0] d, input logic stop1);
      logic [10:0] f;
      f = {1'b1, stop1, d, 1'b0};
      @(posedge core_clk);
      for (int i = 0; i < 11; i++) begin
         rx_line <= f[i];
         repeat (BIT) @(posedge core_clk);
      end
   endtask : send_byte
endmodule : dmx_line_model

// File: verif/tb_top.sv
// self-checking bench: register port, dmx controller and dmx receiver
// assumes: package and header compiled first, checker bound to the design
`timescale 1ns/1ps
`include "dmx_uart_regs.svh"
module tb_top;
   import dmx_uart_pkg::*;
   logic core_clk;
   logic rst_n;
   reg_req_type reg_req;
   logic [15:0] reg_rdata;
   logic rx_pin;
   logic tx_pin;
   logic err_irq;
   int miscompares = 0;
   int compares = 0;

   dmx_uart DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
      .err_irq(err_irq));
   // 16 clocks per bit keeps the run short; the far end matches it
   dmx_line_model #(.BIT(16)) PARTNER (.core_clk(core_clk),
      .tx_line(tx_pin), .rx_line(rx_pin));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic finish_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : finish_test

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_req <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk);
      reg_req <= '0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge core_clk);
      reg_req <= '0;
      #1;
      d = reg_rdata;
   endtask : rd

   task automatic rchk(input logic [3:0] a, input logic [15:0] m,
      input logic [15:0] e);
      logic [15:0] d;
      rd(a, d);
      check(d & m, e);
   endtask : rchk

   task automatic wait_bit(input int b);
      logic [15:0] d;
      int n;
      d = 16'h0000;
      n = 0;
      while (d[b] !== 1'b1 && n < 5000) begin
         rd(`OFF_STATUS, d);
         n++;
      end
      if (n >= 5000) begin
         miscompares++;
         finish_test();
      end
   endtask : wait_bit

   task automatic wait_seen(input int k);
      int n;
      n = 0;
      while (PARTNER.seen_q.size() < k && n < 20000) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 20000) begin
         miscompares++;
         finish_test();
      end
   endtask : wait_seen

   // start code then three data bytes, each only once the buffer is free
   task automatic send_universe(input logic [7:0] base);
      for (int i = 0; i < 4; i++) begin
         wait_bit(`ST_TXRDY);
         wr(`OFF_TXBUF, (i == 0) ? 16'h0000 : {8'h00, base + 8'(i)});
      end
   endtask : send_universe

   initial begin
      repeat (100000) @(posedge core_clk);
      miscompares++;
      finish_test();
   end

   initial begin : main
      rst_n = 1'b0;
      reg_req = '0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      rchk(`OFF_ERRIE, 16'hFFFF, 16'h0000);
      rchk(4'h9, 16'hFFFF, 16'h0000);
      rchk(`OFF_BAUD, 16'hFFFF, 16'h00A0);
      wr(`OFF_ERRIE, 16'h00FF);
      rchk(`OFF_ERRIE, 16'hFFFF, 16'h00FF);
      wr(`OFF_ERRIE, 16'h0000);
      wr(`OFF_BAUD, 16'h0010);
      wr(`OFF_TXCNT, 16'h0002);
      wr(`OFF_CTRL, 16'h009A);
      send_universe(8'h10);
      send_universe(8'h20);
      wait_seen(8);
      check(16'(PARTNER.breaks), 16'h0002);
      for (int i = 0; i < 8; i++)
         check({8'h00, PARTNER.seen_q[i]}, (i % 4 == 0) ? 16'h0000 :
            16'((i / 4 + 1) * 16 + i % 4));
      wait_bit(`ST_SHEMPTY);
      wr(`OFF_CTRL, 16'h008A);
      wr(`OFF_RXFIRST, 16'h0002);
      wr(`OFF_RXLAST, 16'h0003);
      wr(`OFF_CTRL, 16'h00AA);
      PARTNER.send_break(20);
      PARTNER.send_byte(8'h77, 1'b1);
      rchk(`OFF_STATUS, 16'h0024, 16'h0000);
      PARTNER.send_break(25);
      PARTNER.send_byte(8'h55, 1'b1);
      PARTNER.send_byte(8'hC0, 1'b1);
      PARTNER.send_byte(8'hC1, 1'b1);
      rchk(`OFF_STATUS, 16'h0024, 16'h0024);
      rchk(`OFF_RXBUF, 16'h00FF, 16'h0055);
      rchk(`OFF_STATUS, 16'h0020, 16'h0000);
      for (int i = 2; i < 6; i++)
         PARTNER.send_byte(8'hC0 + 8'(i), 1'b1);
      rchk(`OFF_RXBUF, 16'h00FF, 16'h00C2);
      rchk(`OFF_RXBUF, 16'h00FF, 16'h00C3);
      rchk(`OFF_STATUS, 16'h0030, 16'h0000);
      rchk(`OFF_RXBUF, 16'hFFFF, 16'h0000);
      wr(`OFF_STATUS, 16'h001C);
      wr(`OFF_RXFIRST, 16'h0000);
      wr(`OFF_ERRIE, 16'h0002);
      PARTNER.send_break(25);
      PARTNER.send_byte(8'h55, 1'b1);
      PARTNER.send_byte(8'hC0, 1'b1);
      PARTNER.send_byte(8'hC1, 1'b1);
      rchk(`OFF_STATUS, 16'h0014, 16'h0014);
      check({15'h0000, err_irq}, 16'h0001);
      rchk(`OFF_RXBUF, 16'h00FF, 16'h0055);
      rchk(`OFF_RXBUF, 16'h00FF, 16'h00C0);
      rchk(`OFF_STATUS, 16'h0020, 16'h0000);
      PARTNER.send_byte(8'h5A, 1'b0);
      rchk(`OFF_STATUS, 16'h0068, 16'h0068);
      rchk(`OFF_RXBUF, 16'h00FF, 16'h005A);
      wr(`OFF_STATUS, 16'h0008);
      // a break inside the channel window must not leave a byte behind
      PARTNER.send_break(25);
      rchk(`OFF_STATUS, 16'h002C, 16'h0004);
      wr(`OFF_ERRIE, 16'h0000);
      repeat (2) @(posedge core_clk);
      #1;
      check({15'h0000, err_irq}, 16'h0000);
      finish_test();
   end
endmodule : tb_top
